// *** rtl/csf_pkg.sv ***
// Purpose: constants for the charger status and fault register bank
// Assumes: 50 MHz system clock, 8-bit registers behind a two-wire serial port
// Notes: timeout codes map to whole seconds through csf_timeout_sec
package csf_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STAT1 = 8'h0B;
  localparam logic [7:0] ADDR_STAT2 = 8'h0C;
  localparam logic [7:0] ADDR_FAULT = 8'h0D;
  localparam logic [7:0] ADDR_SHORT = 8'h10;
  localparam logic [7:0] FAULT_MASK = 8'h0F;
  localparam logic [7:0] SHORT_MASK = 8'hE7;
  localparam logic [7:0] SHORT_RST = 8'h84;
  localparam logic [7:0] FAULT_RST = 8'h00;
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint SEC_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 20;
  localparam int PEAK_RUN = 4;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK} csf_st_t;
  // timeout code to seconds
  function automatic logic [7:0] csf_timeout_sec(input logic [2:0] sel);
    case (sel)
      3'h0: csf_timeout_sec = 8'h01;
      3'h1: csf_timeout_sec = 8'h02;
      3'h2: csf_timeout_sec = 8'h04;
      3'h3: csf_timeout_sec = 8'h0A;
      3'h4: csf_timeout_sec = 8'h1E;
      3'h5: csf_timeout_sec = 8'h3C;
      3'h6: csf_timeout_sec = 8'h78;
      default: csf_timeout_sec = 8'hB4;
    endcase
  endfunction : csf_timeout_sec
endpackage : csf_pkg

// *** rtl/csf_status_regs.sv ***
// Purpose: charger status, fault and battery short registers with serial slave
// Assumes: all monitor inputs are asynchronous levels from analogue blocks
// Notes: sda is open drain, the pad resolves sda_out/sda_oe
// Function
// - status one bits 7 and 6 show input overvoltage and input valid.
// - status one bit 5 shows input current limited by the blocking switch.
// - status one bit 4 shows die thermal limiting.
// - status one bit 3 latches end of charge and ignores recharge.
// - status one bits 2..0 carry the 3-bit charger state code.
// - status two bits 7..5 carry the thermistor zone code.
// - status two bit 4 is set after four or more successive peak limits.
// - status two bits 2..0 carry the battery band code.
// - fault register holds sticky short, peak, 130 C and 140 C flags, zero at reset.
// - a fault clears only by writing one to it or by a supply power cycle.
// - short timeout select in bits 7..5 picks 1..180 s, reset code 100.
// - short threshold select in bits 2..0 picks 2.0..2.7 V, reset code 100.
// - four successive peak limits shut the charger down unless disabled.
`timescale 1ns/1ns
module csf_status_regs
  import csf_pkg::*;
#(
  parameter int unsigned CYC_PER_SEC = int'(SEC_NS / CLK_PERIOD_NS),
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT  // arbitrary bus address
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic input_overvoltage_flag,
  input wire logic input_valid_flag,
  input wire logic input_current_limited_flag,
  input wire logic die_thermal_limit_flag,
  input wire logic charge_done_event,
  input wire logic [2:0] charger_state_field,
  input wire logic [2:0] thermistor_zone_field,
  input wire logic [2:0] battery_status_field,
  input wire logic switch_cycle_tick,
  input wire logic peak_limit_hit,
  input wire logic overtemp_lower_hit,
  input wire logic overtemp_upper_hit,
  input wire logic battery_below_short,
  input wire logic peak_shutdown_disable,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic peak_shutdown,
  output logic [2:0] short_threshold_select,
  output logic [2:0] short_timeout_select
);
  // ---------------------------------------------------------------
  // reset release and input synchronisers
  // ---------------------------------------------------------------
  logic rst_q1, rst_q2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  logic [21:0] in_s1, in_s2;
  logic ov, vok, ilim, thl, cdone, tick, phit, ot130, ot140, below, dis, scl, sda;
  logic [2:0] chg_st, thr_z, bat_b;
  // two stages before any logic looks at the pins
  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      in_s1 <= 22'h3;
      in_s2 <= 22'h3;
    end else begin
      in_s1 <= {input_overvoltage_flag, input_valid_flag, input_current_limited_flag, die_thermal_limit_flag,
                charge_done_event, charger_state_field, thermistor_zone_field, battery_status_field,
                switch_cycle_tick, peak_limit_hit, overtemp_lower_hit, overtemp_upper_hit,
                battery_below_short, peak_shutdown_disable, scl_in, sda_in};
      in_s2 <= in_s1;
    end
  end
  assign {ov, vok, ilim, thl, cdone, chg_st, thr_z, bat_b, tick, phit, ot130, ot140, below, dis, scl, sda} = in_s2;
  // ---------------------------------------------------------------
  // charger state: latches, peak counter, short timer, faults
  // ---------------------------------------------------------------
  logic vok_d_r, tick_d_r, scl_d_r, sda_d_r;
  logic done_r, done_nxt, sd_r, sd_nxt;
  logic [2:0] pk_r, pk_nxt;
  logic [25:0] pre_r, pre_nxt;
  logic [7:0] sec_r, sec_nxt, flt_r, flt_nxt, cfg_r, cfg_nxt, flt_clr, flt_set;
  logic pwr_drop, tick_rise, wr_stb, pk_evt;
  logic [7:0] wr_ptr, wr_dat;
  assign pwr_drop = vok_d_r & ~vok;
  assign tick_rise = tick & ~tick_d_r;
  always_comb begin
    done_nxt = done_r;
    if (cdone)
      done_nxt = 1'b1;
    else if (pwr_drop)
      done_nxt = 1'b0;
    pk_nxt = pk_r;
    if (tick_rise)
      pk_nxt = !phit ? 3'h0 : (pk_r == 3'(PEAK_RUN)) ? pk_r : pk_r + 3'h1;
    // a parked run at four also makes each hit edge an event, so it re-arms the peak fault after a clear
    pk_evt = tick_rise && phit && pk_nxt == 3'(PEAK_RUN);
    sd_nxt = sd_r;
    if (pwr_drop)
      sd_nxt = 1'b0;
    if (pk_evt && !dis)
      sd_nxt = 1'b1;
    // whole-second prescaler, restarts whenever battery recovers
    pre_nxt = 26'h0;
    sec_nxt = 8'h00;
    if (below) begin
      pre_nxt = (pre_r == 26'(CYC_PER_SEC - 1)) ? 26'h0 : pre_r + 26'h1;
      sec_nxt = sec_r;
      if (pre_r == 26'(CYC_PER_SEC - 1) && sec_r != 8'hFF)
        sec_nxt = sec_r + 8'h01;
    end
    flt_set = {4'h0, below && sec_r >= csf_timeout_sec(cfg_r[7:5]), pk_evt, ot130, ot140};
    flt_clr = (wr_stb && wr_ptr == ADDR_FAULT) ? wr_dat & FAULT_MASK : 8'h00;
    if (pwr_drop)
      flt_clr = FAULT_MASK;
    // set beats clear so a fresh fault is never lost
    flt_nxt = ((flt_r & ~flt_clr) | flt_set) & FAULT_MASK;
    cfg_nxt = cfg_r;
    if (wr_stb && wr_ptr == ADDR_SHORT)
      cfg_nxt = wr_dat & SHORT_MASK;
  end
  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      vok_d_r <= 1'b0;
      tick_d_r <= 1'b0;
      done_r <= 1'b0;
      sd_r <= 1'b0;
      pk_r <= 3'h0;
      pre_r <= 26'h0;
      sec_r <= 8'h00;
      flt_r <= FAULT_RST;
      cfg_r <= SHORT_RST;
    end else begin
      vok_d_r <= vok;
      tick_d_r <= tick;
      done_r <= done_nxt;
      sd_r <= sd_nxt;
      pk_r <= pk_nxt;
      pre_r <= pre_nxt;
      sec_r <= sec_nxt;
      flt_r <= flt_nxt;
      cfg_r <= cfg_nxt;
    end
  end
  assign peak_shutdown = sd_r;
  assign short_timeout_select = cfg_r[7:5];
  assign short_threshold_select = cfg_r[2:0];
  // read decode, unmapped offsets read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      ADDR_STAT1: rd_byte = {ov, vok, ilim, thl, done_r, chg_st};
      ADDR_STAT2: rd_byte = {thr_z, pk_r == 3'(PEAK_RUN), 1'b0, bat_b};
      ADDR_FAULT: rd_byte = flt_r;
      ADDR_SHORT: rd_byte = cfg_r;
      default: rd_byte = 8'h00;
    endcase
  endfunction : rd_byte
  // ---------------------------------------------------------------
  // serial slave: address, pointer, data with auto increment
  // ---------------------------------------------------------------
  csf_st_t st_r, st_nxt, ret_r, ret_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt, rd_now;
  logic oe_r, oe_nxt, scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start_c = scl && scl_d_r && sda_d_r && !sda;
  assign stop_c = scl && scl_d_r && !sda_d_r && sda;
  // a process, not an assign, so the byte follows status changes and not only the pointer
  always_comb begin
    rd_now = rd_byte(ptr_r);
  end
  always_comb begin
    st_nxt = st_r;
    ret_nxt = ret_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    wr_stb = 1'b0;
    wr_ptr = ptr_r;
    wr_dat = sh_r;
    if (start_c) begin
      st_nxt = ST_ADDR;
      bit_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      case (st_r)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          sh_nxt = {sh_r[6:0], sda};
          bit_nxt = bit_r + 4'h1;
        end
        ST_MACK: if (sda) st_nxt = ST_IDLE;   // master nack ends the read
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st_r)
        ST_ADDR: if (bit_r == 4'h8) begin
          st_nxt = (sh_r[7:1] == DEV_ADDR) ? ST_ACK : ST_IDLE;
          oe_nxt = (sh_r[7:1] == DEV_ADDR);
          ret_nxt = sh_r[0] ? ST_RDATA : ST_PTR;
        end
        ST_PTR, ST_WDATA: if (bit_r == 4'h8) begin
          if (st_r == ST_PTR)
            ptr_nxt = sh_r;
          else begin
            wr_stb = 1'b1;
            ptr_nxt = ptr_r + 8'h01;
          end
          st_nxt = ST_ACK;
          oe_nxt = 1'b1;
          ret_nxt = ST_WDATA;
        end
        ST_ACK, ST_MACK: begin
          bit_nxt = 4'h0;
          oe_nxt = 1'b0;
          st_nxt = ret_r;
          // snapshot the byte at the ack edge so it cannot tear mid-byte
          if (ret_r == ST_RDATA) begin
            sh_nxt = rd_now;
            ptr_nxt = ptr_r + 8'h01;
            oe_nxt = ~rd_now[7];
            bit_nxt = 4'h1;
          end
        end
        ST_RDATA: begin
          sh_nxt = {sh_r[6:0], 1'b0};
          oe_nxt = (bit_r == 4'h8) ? 1'b0 : ~sh_r[6];
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h8) st_nxt = ST_MACK;
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      st_r <= ST_IDLE;
      ret_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      oe_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ret_r <= ret_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      scl_d_r <= scl;
      sda_d_r <= sda;
    end
  end
  assign sda_oe = oe_r;
  assign sda_out = 1'b0;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [7:0] stat1_now, stat2_now;
  // status bytes as the host would read them
  always_comb begin
    stat1_now = rd_byte(ADDR_STAT1);
    stat2_now = rd_byte(ADDR_STAT2);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_q2);
  AST_STAT1: assert property ($past(rst_q2, 2) |->
    stat1_now == {$past({input_overvoltage_flag, input_valid_flag, input_current_limited_flag,
    die_thermal_limit_flag}, 2), done_r, $past(charger_state_field, 2)})
    else $error("status one mismatch");
  AST_DONE_HOLD: assert property (done_r && vok_d_r && vok |=> done_r)
    else $error("charge done latch dropped");
  AST_STAT2: assert property ($past(rst_q2, 2) |-> stat2_now[3] == 1'b0 &&
    stat2_now[7:5] == $past(thermistor_zone_field, 2) && stat2_now[2:0] == $past(battery_status_field, 2))
    else $error("status two field mismatch");
  AST_PEAK4: assert property (tick_rise && phit && pk_r == 3'h3 |=> stat2_now[4] && flt_r[2])
    else $error("peak run not flagged");
  AST_SD_ON: assert property (tick_rise && phit && pk_r == 3'h3 && !dis |=> peak_shutdown)
    else $error("shutdown missing");
  AST_SD_DIS: assert property ($rose(peak_shutdown) |-> !$past(dis))
    else $error("shutdown while disabled");
  AST_FLT_KEEP: assert property (!(|($past(flt_r) & ~flt_r & ~$past(flt_clr))))
    else $error("fault cleared without cause");
  AST_CFG_RST: assert property ($rose(rst_q2) |-> cfg_r == SHORT_RST)
    else $error("config reset value");
  AST_SHORT_SET: assert property ($rose(flt_r[3]) |-> $past(below) && $past(sec_r) >= csf_timeout_sec(cfg_r[7:5]))
    else $error("short flag early");
  AST_RSV: assert property ((rd_byte(ADDR_SHORT) & 8'h18) == 8'h00 && flt_r[7:4] == 4'h0)
    else $error("reserved bits nonzero");
  AST_OE: assert property (sda_oe |-> st_r == ST_ACK || st_r == ST_RDATA)
    else $error("sda driven outside ack or read");
  COV_FLT_W1C: cover property (wr_stb && wr_ptr == ADDR_FAULT && |flt_r);
  COV_READ: cover property (st_r == ST_RDATA ##1 st_r == ST_MACK);
  COV_SD: cover property ($rose(peak_shutdown));
  COV_SHORT: cover property ($rose(flt_r[3]));
endmodule : csf_status_regs

// *** tb/csf_status_regs_tb_top.sv ***
// Purpose: self-checking bench for the charger status and fault register bank
// Assumes: one second shortened to ten clocks, serial bus bit-banged by the bench
// Notes: expected values come from a small model kept beside the bus tasks
`timescale 1ns/1ns
module csf_status_regs_tb_top;
  import csf_pkg::*;
  // ---------------------------------------------------------------
  // stimulus, model state and dut
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV = 7'h2A; // arbitrary bus address
  logic clk = 0, rstn = 0, ov = 0, vok = 1, ilim = 0, thl = 0, cde = 0, stk = 0, phit = 0;
  logic otl = 0, otu = 0, bbs = 0, psd = 1, scl = 1, sda_m = 1;
  logic [2:0] cst = 0, thz = 0, bst = 0;
  logic sda_out, sda_oe, pshut, m_done = 0, m_shut = 0, nak;
  logic [2:0] thr_sel, to_sel;
  logic [7:0] m_fault = 0, d;
  logic [2:0] zl [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int err_total = 0, n_compared = 0, cyc = 0, run = 0;
  wire sda;
  // open drain: released line floats high through the pull-up
  assign sda = (sda_oe ? sda_out : 1'b1) & sda_m;
  csf_status_regs #(.CYC_PER_SEC(10), .DEV_ADDR(DEV)) u_dut (.clk(clk), .rstn(rstn),
    .input_overvoltage_flag(ov), .input_valid_flag(vok), .input_current_limited_flag(ilim),
    .die_thermal_limit_flag(thl), .charge_done_event(cde), .charger_state_field(cst),
    .thermistor_zone_field(thz), .battery_status_field(bst), .switch_cycle_tick(stk),
    .peak_limit_hit(phit), .overtemp_lower_hit(otl), .overtemp_upper_hit(otu),
    .battery_below_short(bbs), .peak_shutdown_disable(psd), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .peak_shutdown(pshut), .short_threshold_select(thr_sel),
    .short_timeout_select(to_sel));
  // ---------------------------------------------------------------
  // clock, hang guard, helpers
  // ---------------------------------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end
  // a hung bus transfer ends the run as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // inputs change a fixed 2 ns after each rising edge
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
    end
  endtask : tick
  // sda moves only well inside scl low, never beside an scl edge
  task automatic bitx(input logic b, output logic q);
    sda_m = b;
    tick(6);
    scl = 1;
    tick(8);
    q = sda;
    scl = 0;
    tick(2);
  endtask : bitx
  task automatic xfer(input logic [7:0] v, input logic m, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(v[i], q[i]);
    bitx(m, a);
    ack = !a;
  endtask : xfer
  task automatic sta();
    sda_m = 1;
    tick(4);
    scl = 1;
    tick(8);
    sda_m = 0;
    tick(8);
    scl = 0;
    tick(2);
  endtask : sta
  task automatic sto();
    sda_m = 0;
    tick(6);
    scl = 1;
    tick(8);
    sda_m = 1;
    tick(8);
  endtask : sto
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    logic k0, k1, k2;
    sta();
    xfer({DEV, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    xfer(v, 1'b1, q, k2);
    sto();
    chk({5'h0, k0, k1, k2}, 8'h07);
  endtask : wr
  // read one byte through a repeated start, nack ends it
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic k;
    sta();
    xfer({DEV, 1'b0}, 1'b1, q, k);
    xfer(a, 1'b1, q, k);
    sta();
    xfer({DEV, 1'b1}, 1'b1, q, k);
    xfer(8'hFF, 1'b1, q, k);
    sto();
    chk(q, exp);
  endtask : rchk
  // two bytes in one read, master ack between them, nack on the last
  task automatic rchk2(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic [7:0] q0, q1;
    logic k;
    sta();
    xfer({DEV, 1'b0}, 1'b1, q0, k);
    xfer(a, 1'b1, q0, k);
    sta();
    xfer({DEV, 1'b1}, 1'b1, q0, k);
    xfer(8'hFF, 1'b0, q0, k);
    xfer(8'hFF, 1'b1, q1, k);
    sto();
    chk(q0, e0);
    chk(q1, e1);
  endtask : rchk2
  // one switching cycle; model keeps the successive peak count
  task automatic ptick(input logic h);
    phit = h;
    tick(4);
    stk = 1;
    tick(4);
    stk = 0;
    tick(4);
    run = h ? run + 1 : 0;
    if (run >= 4) m_fault[2] = 1'b1;
    if (run >= 4 && !psd) m_shut = 1'b1;
  endtask : ptick
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(93885));
    tick(3);
    rstn = 1;
    tick(8);
    rchk(ADDR_SHORT, 8'h84);
    chk({2'h0, thr_sel, to_sel}, 8'h24);
    rchk(ADDR_FAULT, 8'h00);
    rchk(8'h0E, 8'h00);
    // a transfer to another bus address is ignored, config keeps its reset code
    sta();
    xfer({DEV ^ 7'h01, 1'b0}, 1'b1, d, nak);
    xfer(ADDR_SHORT, 1'b1, d, nak);
    xfer(8'h00, 1'b1, d, nak);
    sto();
    chk({7'h0, nak}, 8'h00);
    rchk(ADDR_SHORT, SHORT_RST);
    for (int i = 0; i < 8; i++) begin
      {ov, ilim, thl} = 3'($urandom);
      cst = i[2:0];
      thz = zl[$urandom_range(5)];
      bst = 3'($urandom_range(4));
      tick(4);
      rchk(ADDR_STAT1, {ov, vok, ilim, thl, m_done, cst});
      rchk(ADDR_STAT2, {thz, 1'b0, 1'b0, bst});
    end
    rchk2(ADDR_STAT1, {ov, vok, ilim, thl, m_done, cst}, {thz, 1'b0, 1'b0, bst});
    cde = 1;
    tick(4);
    cde = 0;
    m_done = 1;
    wr(ADDR_STAT1, 8'h00);
    rchk(ADDR_STAT1, {ov, vok, ilim, thl, m_done, cst});
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      wr(ADDR_SHORT, d);
      rchk(ADDR_SHORT, d & SHORT_MASK);
      chk({2'h0, thr_sel, to_sel}, {2'h0, d[2:0], d[7:5]});
    end
    // short shorter than the 2 s timeout must not flag, a long one must
    wr(ADDR_SHORT, 8'h20);
    bbs = 1;
    tick(12);
    bbs = 0;
    rchk(ADDR_FAULT, m_fault);
    wr(ADDR_SHORT, 8'h00);
    bbs = 1;
    tick(30);
    bbs = 0;
    m_fault[3] = 1'b1;
    rchk(ADDR_FAULT, m_fault);
    {otl, otu} = 2'h3;
    tick(4);
    {otl, otu} = 2'h0;
    m_fault[1:0] = 2'h3;
    rchk(ADDR_FAULT, m_fault);
    wr(ADDR_FAULT, 8'h00);
    rchk(ADDR_FAULT, m_fault);
    wr(ADDR_FAULT, 8'hF9);
    m_fault = m_fault & 8'h06;
    rchk(ADDR_FAULT, m_fault);
    // peak run: three hits stay quiet, the fourth flags, a miss clears
    repeat (3) ptick(1'b1);
    rchk(ADDR_STAT2, {thz, 1'b0, 1'b0, bst});
    ptick(1'b1);
    rchk(ADDR_STAT2, {thz, 1'b1, 1'b0, bst});
    rchk(ADDR_FAULT, m_fault);
    chk({7'h0, pshut}, {7'h0, m_shut});
    ptick(1'b0);
    rchk(ADDR_STAT2, {thz, 1'b0, 1'b0, bst});
    psd = 0;
    repeat (4) ptick(1'b1);
    chk({7'h0, pshut}, {7'h0, m_shut});
    // supply power cycle clears the sticky state
    vok = 0;
    tick(6);
    vok = 1;
    m_fault = 0;
    m_done = 0;
    m_shut = 0;
    tick(6);
    rchk(ADDR_FAULT, m_fault);
    rchk(ADDR_STAT1, {ov, vok, ilim, thl, m_done, cst});
    chk({7'h0, pshut}, {7'h0, m_shut});
    test_done();
  end
endmodule : csf_status_regs_tb_top
